// file: fpcc_pkg.sv
// Package with encodings, field positions and register map of the FP compare unit.
package fpcc_pkg;
    localparam logic [5:0] FPCC_FPU_MAJOR_OPCODE = 6'h11;
    localparam logic [1:0] FPCC_FUNC_COMPARE     = 2'h3;
    localparam int         FPCC_OPC_HI           = 31;
    localparam int         FPCC_OPC_LO           = 26;
    localparam int         FPCC_FMT_HI           = 25;
    localparam int         FPCC_FMT_LO           = 21;
    localparam int         FPCC_FT_HI            = 20;
    localparam int         FPCC_FT_LO            = 16;
    localparam int         FPCC_FS_HI            = 15;
    localparam int         FPCC_FS_LO            = 11;
    localparam int         FPCC_CC_HI            = 10;
    localparam int         FPCC_CC_LO            = 8;
    localparam int         FPCC_FC_HI            = 5;
    localparam int         FPCC_FC_LO            = 4;
    localparam int         FPCC_COND_HI          = 3;
    localparam int         FPCC_COND_LO          = 0;
    localparam logic [4:0] FPCC_FMT_SINGLE       = 5'h10;
    localparam logic [4:0] FPCC_FMT_DOUBLE       = 5'h11;
    localparam logic [4:0] FPCC_FMT_PAIRED       = 5'h16;
    localparam int         FPCC_NUM_CC           = 8;

    // Register byte addresses on the Wishbone slave.
    localparam logic [3:0] FPCC_ADDR_CC          = 4'h0;
    localparam logic [3:0] FPCC_ADDR_CTRL        = 4'h4;
    localparam logic [3:0] FPCC_ADDR_STATUS      = 4'h8;
    localparam logic [3:0] FPCC_ADDR_MASK        = 4'hc;
    // Control bits.
    localparam int         FPCC_CTRL_INV_EN      = 0;
    localparam int         FPCC_CTRL_FR64        = 1;
    // Status and mask bits.
    localparam int         FPCC_ST_INVALID       = 0;
    localparam int         FPCC_ST_EXC_TAKEN     = 1;
    localparam int         FPCC_ST_RESERVED_INS  = 2;
    localparam int         FPCC_ST_COP_UNUSABLE  = 3;
    localparam int         FPCC_ST_BITS          = 4;

    typedef struct packed {
        logic [3:0] cond;
        logic [2:0] cc_sel;
        logic [4:0] fmt;
        logic [4:0] ft_idx;
        logic [4:0] fs_idx;
        logic       is_compare;
    } fpcc_decode_t;

    typedef struct packed {
        logic less;
        logic equal;
        logic unordered;
        logic invalid;
    } fpcc_rel_t;
endpackage

// file: fpcc_unit.sv
// Floating-point compare and condition code unit with a Wishbone register slave.
//
// Our own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/10ps

module fpcc_unit
    import fpcc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic        issue_valid,
    input  wire logic [31:0] issue_instr,
    input  wire logic [63:0] first_source_operand,
    input  wire logic [63:0] second_source_operand,
    input  wire logic        fpu_major_opcode_usable,
    input  wire logic [2:0]  branch_cc_sel,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             done,
    output logic             invalid_exc,
    output logic             reserved_ins_exc,
    output logic             cop_unusable_exc,
    output logic [7:0]       cond_codes,
    output logic             branch_on_fp_true,
    output logic             branch_on_fp_false,
    output logic             irq
);

    // Single-precision class and ordering, exact on the raw bits.
    function automatic fpcc_rel_t cmp_single(input logic [31:0] a, input logic [31:0] b,
                                             input logic signaling);
        fpcc_rel_t r;
        logic      a_nan;
        logic      b_nan;
        logic      a_snan;
        logic      b_snan;
        logic      a_zero;
        logic      b_zero;
        a_nan  = (a[30:23] == 8'hff) && (a[22:0] != 23'h0);
        b_nan  = (b[30:23] == 8'hff) && (b[22:0] != 23'h0);
        a_snan = a_nan && !a[22];
        b_snan = b_nan && !b[22];
        a_zero = (a[30:0] == 31'h0);
        b_zero = (b[30:0] == 31'h0);
        r.invalid   = a_snan || b_snan || (signaling && (a_nan || b_nan));
        r.unordered = a_nan || b_nan;
        r.equal     = !r.unordered && ((a == b) || (a_zero && b_zero));
        if (r.unordered || r.equal)
        begin
            r.less = 1'b0;
        end
        else if (a[31] != b[31])
        begin
            r.less = a[31];
        end
        else
        begin
            r.less = a[31] ? (a[30:0] > b[30:0]) : (a[30:0] < b[30:0]);
        end
        return r;
    endfunction

    function automatic fpcc_rel_t cmp_double(input logic [63:0] a, input logic [63:0] b,
                                             input logic signaling);
        fpcc_rel_t r;
        logic      a_nan;
        logic      b_nan;
        logic      a_snan;
        logic      b_snan;
        logic      a_zero;
        logic      b_zero;
        a_nan  = (a[62:52] == 11'h7ff) && (a[51:0] != 52'h0);
        b_nan  = (b[62:52] == 11'h7ff) && (b[51:0] != 52'h0);
        a_snan = a_nan && !a[51];
        b_snan = b_nan && !b[51];
        a_zero = (a[62:0] == 63'h0);
        b_zero = (b[62:0] == 63'h0);
        r.invalid   = a_snan || b_snan || (signaling && (a_nan || b_nan));
        r.unordered = a_nan || b_nan;
        r.equal     = !r.unordered && ((a == b) || (a_zero && b_zero));
        if (r.unordered || r.equal)
        begin
            r.less = 1'b0;
        end
        else if (a[63] != b[63])
        begin
            r.less = a[63];
        end
        else
        begin
            r.less = a[63] ? (a[62:0] > b[62:0]) : (a[62:0] < b[62:0]);
        end
        return r;
    endfunction

    function automatic logic predicate(input logic [3:0] cond, input fpcc_rel_t r);
        return (cond[2] & r.less) | (cond[1] & r.equal) | (cond[0] & r.unordered);
    endfunction

    logic [31:0]             ctrl;
    logic [FPCC_ST_BITS-1:0] status;
    logic [FPCC_ST_BITS-1:0] mask;

    // Instruction decode.
    fpcc_decode_t dec;
    assign dec.is_compare = (issue_instr[FPCC_OPC_HI:FPCC_OPC_LO] == FPCC_FPU_MAJOR_OPCODE)
                          && (issue_instr[FPCC_FC_HI:FPCC_FC_LO] == FPCC_FUNC_COMPARE);
    assign dec.cond   = issue_instr[FPCC_COND_HI:FPCC_COND_LO];
    assign dec.cc_sel = issue_instr[FPCC_CC_HI:FPCC_CC_LO];
    assign dec.fmt    = issue_instr[FPCC_FMT_HI:FPCC_FMT_LO];
    assign dec.ft_idx = issue_instr[FPCC_FT_HI:FPCC_FT_LO];
    assign dec.fs_idx = issue_instr[FPCC_FS_HI:FPCC_FS_LO];

    wire logic is_single = (dec.fmt == FPCC_FMT_SINGLE);
    wire logic is_double = (dec.fmt == FPCC_FMT_DOUBLE);
    wire logic is_paired = (dec.fmt == FPCC_FMT_PAIRED);
    // Paired compares need an even select and 64-bit register mode; otherwise refused.
    wire logic paired_ok = is_paired && !dec.cc_sel[0] && ctrl[FPCC_CTRL_FR64];
    wire logic fmt_ok    = is_single || is_double || paired_ok;

    wire logic go        = issue_valid && dec.is_compare;
    wire logic unusable  = go && !fpu_major_opcode_usable;
    wire logic reserved  = go && fpu_major_opcode_usable && !fmt_ok;
    wire logic exec      = go && fpu_major_opcode_usable && fmt_ok;

    wire fpcc_rel_t rel_lo = is_double
        ? cmp_double(first_source_operand, second_source_operand, dec.cond[3])
        : cmp_single(first_source_operand[31:0], second_source_operand[31:0], dec.cond[3]);
    wire fpcc_rel_t rel_hi = cmp_single(first_source_operand[63:32],
                                        second_source_operand[63:32], dec.cond[3]);

    wire logic res_lo    = predicate(dec.cond, rel_lo);
    wire logic res_hi    = predicate(dec.cond, rel_hi);
    wire logic raised    = exec && (rel_lo.invalid || (is_paired && rel_hi.invalid));
    wire logic trap      = raised && ctrl[FPCC_CTRL_INV_EN];
    wire logic write_cc  = exec && !trap;

    logic [7:0] next_cond_codes;
    always_comb
    begin
        next_cond_codes = cond_codes;
        if (write_cc)
        begin
            next_cond_codes[dec.cc_sel] = res_lo;
            if (is_paired)
            begin
                next_cond_codes[dec.cc_sel + 3'h1] = res_hi;
            end
        end
    end

    // The branch decision looks at the freshly updated bits so a compare can feed
    // a branch issued in the very next cycle.
    wire logic branch_bit = next_cond_codes[branch_cc_sel];

    // Wishbone decode.
    wire logic        wb_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic        wb_wr     = wb_req && wb_we_i && wb_sel_i[0];
    wire logic        wr_ctrl   = wb_wr && (wb_adr_i == FPCC_ADDR_CTRL);
    wire logic        wr_status = wb_wr && (wb_adr_i == FPCC_ADDR_STATUS);
    wire logic        wr_mask   = wb_wr && (wb_adr_i == FPCC_ADDR_MASK);
    wire logic [31:0] rd_data   =
        (wb_adr_i == FPCC_ADDR_CC)     ? {24'h0, cond_codes} :
        (wb_adr_i == FPCC_ADDR_CTRL)   ? ctrl :
        (wb_adr_i == FPCC_ADDR_STATUS) ? {28'h0, status} :
        (wb_adr_i == FPCC_ADDR_MASK)   ? {28'h0, mask} : 32'h0;

    wire logic [FPCC_ST_BITS-1:0] events = {unusable, reserved, trap, raised};
    // A new event wins over a write-one-to-clear in the same cycle.
    wire logic [FPCC_ST_BITS-1:0] next_status =
        (status & ~(wr_status ? wb_dat_i[FPCC_ST_BITS-1:0] : 4'h0)) | events;

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            ctrl   <= 32'h0;
            status <= 4'h0;
            mask   <= 4'h0;
        end
        else
        begin
            status <= next_status;
            if (wr_ctrl)
            begin
                ctrl <= {30'h0, wb_dat_i[FPCC_CTRL_FR64], wb_dat_i[FPCC_CTRL_INV_EN]};
            end
            if (wr_mask)
            begin
                mask <= wb_dat_i[FPCC_ST_BITS-1:0];
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end
        else
        begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? rd_data : 32'h0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            cond_codes         <= 8'h0;
            done               <= 1'b0;
            invalid_exc        <= 1'b0;
            reserved_ins_exc   <= 1'b0;
            cop_unusable_exc   <= 1'b0;
            branch_on_fp_true  <= 1'b0;
            branch_on_fp_false <= 1'b1;
            irq                <= 1'b0;
        end
        else
        begin
            cond_codes         <= next_cond_codes;
            done               <= go;
            invalid_exc        <= trap;
            reserved_ins_exc   <= reserved;
            cop_unusable_exc   <= unusable;
            branch_on_fp_true  <= branch_bit;
            branch_on_fp_false <= !branch_bit;
            irq                <= |(next_status & mask);
        end
    end

endmodule

// file: fpcc_unit_chk.sv
// Port-level assertions for the FP compare unit.
`timescale 1ns/10ps
module fpcc_unit_chk
    import fpcc_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        srst,
    input wire logic        issue_valid,
    input wire logic [31:0] issue_instr,
    input wire logic        fpu_major_opcode_usable,
    input wire logic [2:0]  branch_cc_sel,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic        done,
    input wire logic        invalid_exc,
    input wire logic        reserved_ins_exc,
    input wire logic        cop_unusable_exc,
    input wire logic [7:0]  cond_codes,
    input wire logic        branch_on_fp_true,
    input wire logic        branch_on_fp_false
);
    wire logic [4:0] fmt    = issue_instr[25:21];
    wire logic       is_cmp = issue_valid && issue_instr[31:26] == FPCC_FPU_MAJOR_OPCODE
                              && issue_instr[5:4] == FPCC_FUNC_COMPARE;
    wire logic       fmt_ok = fmt == FPCC_FMT_SINGLE || fmt == FPCC_FMT_DOUBLE
                              || fmt == FPCC_FMT_PAIRED;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    property p_done; is_cmp |=> done; endproperty
    a_done: assert property (p_done) else $error("no done after compare");
    property p_no_done; !is_cmp |=> !done; endproperty
    a_no_done: assert property (p_no_done) else $error("done without compare");
    property p_keep; invalid_exc || reserved_ins_exc || cop_unusable_exc |-> $stable(cond_codes); endproperty
    a_keep: assert property (p_keep) else $error("cond codes written on exception");
    property p_write; $changed(cond_codes) && !$past(srst) |-> $past(is_cmp) && $past(fpu_major_opcode_usable); endproperty
    a_write: assert property (p_write) else $error("cond codes changed without compare");
    property p_bfalse; branch_on_fp_false == !branch_on_fp_true; endproperty
    a_bfalse: assert property (p_bfalse) else $error("branch outputs not inverse");
    property p_btrue; !$past(srst) |-> branch_on_fp_true == cond_codes[$past(branch_cc_sel)]; endproperty
    a_btrue: assert property (p_btrue) else $error("branch true not selected bit");
    property p_cop; is_cmp && !fpu_major_opcode_usable |=> cop_unusable_exc && done && !invalid_exc; endproperty
    a_cop: assert property (p_cop) else $error("coprocessor unusable missing");
    property p_res; is_cmp && fpu_major_opcode_usable && !fmt_ok |=> reserved_ins_exc; endproperty
    a_res: assert property (p_res) else $error("reserved instruction missing");
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("bus ack not a single pulse");
endmodule

// file: fpcc_pipe_model.sv
// Behavioural pipeline that issues compare instructions to the unit.
`timescale 1ns/10ps
module fpcc_pipe_model
(
    input  wire logic   ref_clk,
    output logic        issue_valid,
    output logic [31:0] issue_instr,
    output logic [63:0] first_source_operand,
    output logic [63:0] second_source_operand
);
    initial
    begin
        issue_valid = 1'b0;
        issue_instr = 32'h0;
        first_source_operand = 64'h0;
        second_source_operand = 64'h0;
    end
    // Operands are inverted while idle so a stale value is never mistaken for a live one.
    task automatic issue(input logic [31:0] instr, input logic [63:0] a, input logic [63:0] b);
        @(posedge ref_clk);
        issue_valid <= 1'b1;
        issue_instr <= instr;
        first_source_operand <= a;
        second_source_operand <= b;
        @(posedge ref_clk);
        issue_valid <= 1'b0;
        first_source_operand <= ~a;
        second_source_operand <= ~b;
    endtask
endmodule

// file: testbench.sv
// Self-checking testbench of the FP compare unit.
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    import fpcc_pkg::*;
    logic        ref_clk, srst, fpu_major_opcode_usable, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [2:0]  branch_cc_sel;
    logic [3:0]  wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, issue_instr, rd;
    logic [63:0] fs_v, ft_v;
    logic [7:0]  cond_codes;
    logic        issue_valid, wb_ack_o, done, invalid_exc, reserved_ins_exc, cop_unusable_exc;
    logic        branch_on_fp_true, branch_on_fp_false, irq, e;
    int          fail_count, n_tests;
    localparam logic [31:0] ONE = 32'h3f800000, TWO = 32'h40000000, QN = 32'h7fc00000;
    fpcc_pipe_model u_pipe (.ref_clk(ref_clk), .issue_valid(issue_valid),
        .issue_instr(issue_instr), .first_source_operand(fs_v), .second_source_operand(ft_v));
    fpcc_unit u_dut (.ref_clk(ref_clk), .srst(srst), .issue_valid(issue_valid),
        .issue_instr(issue_instr), .first_source_operand(fs_v), .second_source_operand(ft_v),
        .fpu_major_opcode_usable(fpu_major_opcode_usable), .branch_cc_sel(branch_cc_sel), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .done(done),
        .invalid_exc(invalid_exc), .reserved_ins_exc(reserved_ins_exc),
        .cop_unusable_exc(cop_unusable_exc), .cond_codes(cond_codes),
        .branch_on_fp_true(branch_on_fp_true), .branch_on_fp_false(branch_on_fp_false), .irq(irq));
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
        int i;
        @(posedge ref_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
        i = 0;
        do begin @(posedge ref_clk); i++; end while (wb_ack_o !== 1'b1 && i < 20);
        rd = wb_dat_o;
        `CHK(wb_ack_o, 1'b1)
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task automatic cmp(input logic [4:0] f, input logic [2:0] cc, input logic [3:0] c,
                       input logic [63:0] a, input logic [63:0] b);
        branch_cc_sel <= cc;
        u_pipe.issue({FPCC_FPU_MAJOR_OPCODE, f, 10'h041, cc, 2'h0, FPCC_FUNC_COMPARE, c}, a, b);
        #1;
    endtask
    task automatic t_preds;
        for (int k = 0; k < 4; k++)
            for (int c = 0; c < 16; c++)
            begin
                case (k)
                    0: cmp(FPCC_FMT_SINGLE, c[2:0], c[3:0], ONE, TWO);
                    1: cmp(FPCC_FMT_SINGLE, c[2:0], c[3:0], 64'h0, 64'h80000000);
                    2: cmp(FPCC_FMT_SINGLE, c[2:0], c[3:0], QN, ONE);
                    default: cmp(FPCC_FMT_SINGLE, c[2:0], c[3:0], TWO, ONE);
                endcase
                e = (c[2] && k == 0) || (c[1] && k == 1) || (c[0] && k == 2);
                `CHK(done, 1'b1)
                `CHK(cond_codes[c[2:0]], e)
                `CHK(branch_on_fp_true, e)
                `CHK(branch_on_fp_false, !e)
            end
        wb(1'b0, FPCC_ADDR_STATUS, 32'h0);
        `CHK(rd[0], 1'b1)
        wb(1'b1, FPCC_ADDR_STATUS, 32'hf);
    endtask
    task automatic t_wide;
        cmp(FPCC_FMT_DOUBLE, 3'h1, 4'h4, 64'h3ff0000000000000, 64'h3ff0000000000001);
        `CHK(cond_codes[1], 1'b1)
        wb(1'b1, FPCC_ADDR_CTRL, 32'h2);
        cmp(FPCC_FMT_PAIRED, 3'h2, 4'h4, {ONE, QN}, {TWO, ONE});
        `CHK(cond_codes[3:2], 2'b10)
        cmp(FPCC_FMT_PAIRED, 3'h4, 4'h2, {ONE, ONE}, {ONE, ONE});
        `CHK(cond_codes[5:4], 2'b11)
    endtask
    task automatic t_invalid;
        wb(1'b1, FPCC_ADDR_CTRL, 32'h3);
        wb(1'b1, FPCC_ADDR_MASK, 32'h1);
        cmp(FPCC_FMT_PAIRED, 3'h4, 4'h2, {32'h7f800001, ONE}, {ONE, ONE});
        `CHK(invalid_exc, 1'b1)
        `CHK(cond_codes[5:4], 2'b11)
        `CHK(irq, 1'b1)
        wb(1'b1, FPCC_ADDR_MASK, 32'h0);
        @(posedge ref_clk); #1;
        `CHK(irq, 1'b0)
        wb(1'b1, FPCC_ADDR_STATUS, 32'hf);
        wb(1'b1, FPCC_ADDR_MASK, 32'h1);
        cmp(FPCC_FMT_SINGLE, 3'h0, 4'h2, QN, ONE);
        `CHK(invalid_exc, 1'b0)
        cmp(FPCC_FMT_SINGLE, 3'h0, 4'ha, QN, ONE);
        `CHK(invalid_exc, 1'b1)
        wb(1'b1, FPCC_ADDR_STATUS, 32'hf);
        @(posedge ref_clk); #1;
        `CHK(irq, 1'b0)
    endtask
    task automatic t_refuse;
        fpu_major_opcode_usable <= 1'b0;
        cmp(FPCC_FMT_SINGLE, 3'h0, 4'h2, ONE, ONE);
        `CHK(cop_unusable_exc, 1'b1)
        fpu_major_opcode_usable <= 1'b1;
        cmp(5'h12, 3'h0, 4'h2, ONE, ONE);
        `CHK(reserved_ins_exc, 1'b1)
        cmp(FPCC_FMT_PAIRED, 3'h1, 4'h2, ONE, ONE);
        `CHK(reserved_ins_exc, 1'b1)
        wb(1'b1, FPCC_ADDR_CTRL, 32'h0);
        cmp(FPCC_FMT_PAIRED, 3'h0, 4'h2, ONE, ONE);
        `CHK(reserved_ins_exc, 1'b1)
        u_pipe.issue(32'h48000032, 64'h0, 64'h0);
        #1;
        `CHK(done, 1'b0)
        wb(1'b0, 4'h2, 32'h0);
        `CHK(rd, 32'h0)
    endtask
    task automatic finish_test;
        $display("mismatches=%0d comparisons=%0d", fail_count, n_tests);
        if (fail_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial
    begin
        #100000;
        fail_count++;
        finish_test();
    end
    initial
    begin
        {srst, fpu_major_opcode_usable, wb_cyc_i, wb_stb_i, wb_we_i} = 5'b11000;
        {branch_cc_sel, wb_adr_i, wb_dat_i} = '0;
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        t_preds();
        t_wide();
        t_invalid();
        t_refuse();
        finish_test();
    end
endmodule
bind fpcc_unit fpcc_unit_chk u_chk (.ref_clk(ref_clk), .srst(srst), .issue_valid(issue_valid),
    .issue_instr(issue_instr), .fpu_major_opcode_usable(fpu_major_opcode_usable), .branch_cc_sel(branch_cc_sel),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .done(done),
    .invalid_exc(invalid_exc), .reserved_ins_exc(reserved_ins_exc),
    .cop_unusable_exc(cop_unusable_exc), .cond_codes(cond_codes),
    .branch_on_fp_true(branch_on_fp_true), .branch_on_fp_false(branch_on_fp_false));
